// ==== hdl/fhe_packet_encoder.sv ====
// Frequency-hopped binary FSK packet encoder, message in and hops out.
// How it works
// - A 56-bit message gets an 8-bit check appended, giving 64 bits.
// - The reference message must produce check value 11110100.
// - A rate one-half, constraint length nine encoder codes the word.
// - Generators tap delays 0,1,2,3,5,7,8 and 0,2,3,4,8, summed mod two.
// - Eight zero bits flush the encoder, giving 144 coded symbols.
// - Each input bit yields first then second generator symbol.
// - Coded symbols are interleaved with prime step 13, count unchanged.
// - Hop arithmetic is modulo 47 with vector length three.
// - Matrix columns are powers of 5, each column times the first.
// - Hop index is a parameter row vector times the matrix, mod 47.
// - Default hops start 5, 25, 31, 14, 23, 21, 11, 8.
// - 32 preamble hops precede 144 message hops: 176 in all.
// - Preamble symbols are a fixed 15-bit m-sequence sent twice plus two zeros.
// - No idle chip between preamble and message chips.
// - Each hop carries a block index and a slot symbol.
// - Tone bin is block index times two plus slot plus one.
// - One hop is released per 12.5 ms chip period.
// - Cargo uses the same encoder and interleaver as the message.
// - Cargo hops follow the last baseline hop with no gap.
// - Cargo gets a 16-bit check appended before coding.
`timescale 1ns/1ps
`include "fhe_regs.svh"
module fhe_packet_encoder
    import fhe_pkg::*;
#(
    parameter int unsigned CHIP_CYCLES = `FHE_CHIP_PERIOD_NS
                                         / `FHE_CLK_PERIOD_NS,
    parameter logic [7:0]  CRC8_POLY   = `FHE_CRC8_POLY,
    parameter logic [15:0] CRC16_POLY  = `FHE_CRC16_POLY,
    parameter logic [5:0]  ROW0        = 6'h00,
    parameter logic [5:0]  ROW1        = 6'h01,
    parameter logic [5:0]  ROW2        = 6'h00
)
(
    // Clock and reset.
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // Message source.
    input  wire logic       msg_valid,
    output logic            msg_ready,
    input  wire fhe_msg_s   msg,
    // Cargo bytes.
    input  wire logic       cargo_valid,
    output logic            cargo_ready,
    input  wire logic [7:0] cargo_byte,
    // Hops to the chip modulator.
    output logic            hop_valid,
    input  wire logic       hop_ready,
    output fhe_hop_s        hop
);
    localparam int TW = $clog2(CHIP_CYCLES + 1);
    localparam logic [TW-1:0] TMR_LOAD = TW'(CHIP_CYCLES - 1);
    localparam logic [31:0]   PRE_PAT  = `FHE_PRE_PATTERN;

    function automatic logic [5:0] mulmod(input logic [5:0] a,
                                          input logic [5:0] b);
        logic [11:0] pr;
        pr = {6'h00, a} * {6'h00, b};
        mulmod = 6'(pr % {6'h00, `FHE_PRIME});
    endfunction

    function automatic logic [5:0] addmod(input logic [5:0] a,
                                          input logic [5:0] b);
        logic [6:0] s;
        s = {1'b0, a} + {1'b0, b};
        addmod = (s >= {1'b0, `FHE_PRIME}) ? 6'(s - {1'b0, `FHE_PRIME})
                                           : s[5:0];
    endfunction

    fhe_state_e         state_r, state_nxt;
    logic               seg_r, seg_nxt;
    logic [6:0]         cnt_r, cnt_nxt;
    logic               sub_r, sub_nxt;
    logic [8:0]         pos_r, pos_nxt;
    logic [7:0]         sr_r, sr_nxt;
    logic [55:0]        data_r, data_nxt;
    logic [15:0]        crc_r, crc_nxt;
    logic               byte_ok_r, byte_ok_nxt;
    logic               g2_r, g2_nxt;
    logic [3:0]         clen_r, clen_nxt;
    logic               ref_r, ref_nxt;
    logic [8:0]         hop_cnt_r, hop_cnt_nxt;
    logic [TW-1:0]      tmr_r, tmr_nxt;
    logic [5:0]         p1_r, p1_nxt;
    logic [5:0]         p2_r, p2_nxt;

    logic [6:0]         pay_bits, crc_end, nbits;
    logic [8:0]         seg_len, base_off, pos_step;
    logic [8:0]         total_hops, cargo_syms;
    logic               in_pay, in_crc, need_byte, go, enc_bit;
    logic [8:0]         tap_vec;
    logic               g1, g2, last_bit;
    logic [15:0]        crc_poly, crc_shift;
    logic               wr_en, wr_data, rd_data, sym;
    logic [8:0]         wr_addr, rd_addr;
    logic [5:0]         blk;
    logic               hop_push, buf_in_ready;
    fhe_hop_s           hop_in;

    // Segment geometry: baseline message or cargo.
    always_comb
    begin
        pay_bits   = seg_r ? {clen_r, 3'b000} : `FHE_MSG_BITS;
        crc_end    = pay_bits + (seg_r ? `FHE_CRC16_W : `FHE_CRC8_W);
        nbits      = crc_end + `FHE_FLUSH_BITS;
        seg_len    = {1'b0, nbits, 1'b0};
        base_off   = seg_r ? `FHE_BASE_SYMS : 9'h000;
        cargo_syms = (clen_r == 4'h0) ? 9'h000
                     : 9'({clen_r, 4'h0} + 9'd48);
        total_hops = `FHE_PRE_HOPS + `FHE_BASE_SYMS + cargo_syms;
        in_pay     = cnt_r < pay_bits;
        in_crc     = !in_pay && (cnt_r < crc_end);
        need_byte  = seg_r && in_pay && (cnt_r[2:0] == 3'h0)
                     && !byte_ok_r && !sub_r;
        go         = (state_r == FHE_ENC) && !need_byte;
        enc_bit    = in_pay ? data_r[55] : (in_crc ? crc_r[15] : 1'b0);
        tap_vec    = {sr_r, enc_bit};
        g1         = ^(tap_vec & `FHE_G1_TAPS);
        g2         = ^(tap_vec & `FHE_G2_TAPS);
        last_bit   = sub_r && (cnt_r == nbits - 7'd1);
        crc_poly   = seg_r ? CRC16_POLY : {CRC8_POLY, 8'h00};
        crc_shift  = {crc_r[14:0], 1'b0}
                     ^ ((enc_bit ^ crc_r[15]) ? crc_poly : 16'h0000);
        pos_step   = pos_r + `FHE_ILV_STEP;
        wr_en      = go;
        wr_data    = sub_r ? g2_r : g1;
        wr_addr    = base_off + pos_r;
        rd_addr    = hop_cnt_r - `FHE_PRE_HOPS;
        sym        = (hop_cnt_r < `FHE_PRE_HOPS)
                     ? PRE_PAT[5'd31 - hop_cnt_r[4:0]]
                     : rd_data;
        blk        = addmod(addmod(ROW0, mulmod(ROW1, p1_r)),
                            mulmod(ROW2, p2_r));
        hop_in.block_idx = blk;
        hop_in.slot      = sym;
        hop_in.tone_bin  = 7'({blk, 1'b0} + 7'(sym) + 7'd1);
        hop_in.last      = hop_cnt_r == total_hops - 9'd1;
        hop_push   = (state_r == FHE_EMIT) && (tmr_r == '0)
                     && buf_in_ready;
        msg_ready  = state_r == FHE_IDLE;
        cargo_ready = (state_r == FHE_ENC) && need_byte;
    end

    // Next-state logic for encoding and hop emission.
    always_comb
    begin
        state_nxt   = state_r;
        seg_nxt     = seg_r;
        cnt_nxt     = cnt_r;
        sub_nxt     = sub_r;
        pos_nxt     = pos_r;
        sr_nxt      = sr_r;
        data_nxt    = data_r;
        crc_nxt     = crc_r;
        byte_ok_nxt = byte_ok_r;
        g2_nxt      = g2_r;
        clen_nxt    = clen_r;
        ref_nxt     = ref_r;
        hop_cnt_nxt = hop_cnt_r;
        p1_nxt      = p1_r;
        p2_nxt      = p2_r;
        tmr_nxt     = (tmr_r != '0) ? tmr_r - TW'(1) : tmr_r;
        case (state_r)
            FHE_IDLE:
            begin
                if (msg_valid)
                begin
                    state_nxt   = FHE_ENC;
                    seg_nxt     = 1'b0;
                    cnt_nxt     = 7'h00;
                    sub_nxt     = 1'b0;
                    pos_nxt     = 9'h000;
                    sr_nxt      = 8'h00;
                    data_nxt    = msg.msg;
                    crc_nxt     = `FHE_CRC_INIT;
                    byte_ok_nxt = 1'b0;
                    clen_nxt    = (msg.cargo_len > `FHE_MAX_CARGO)
                                  ? `FHE_MAX_CARGO : msg.cargo_len;
                    ref_nxt     = msg.msg == `FHE_REF_MSG;
                    hop_cnt_nxt = 9'h000;
                    p1_nxt      = `FHE_ALPHA;
                    p2_nxt      = `FHE_ALPHA_SQ;
                end
            end
            FHE_ENC:
            begin
                if (cargo_valid && cargo_ready)
                begin
                    data_nxt[55:48] = cargo_byte;
                    byte_ok_nxt     = 1'b1;
                end
                if (go)
                begin
                    pos_nxt = (pos_step >= seg_len) ? pos_step - seg_len
                                                    : pos_step;
                    if (!sub_r)
                    begin
                        sub_nxt = 1'b1;
                        g2_nxt  = g2;
                        sr_nxt  = {sr_r[6:0], enc_bit};
                        if (in_pay)
                        begin
                            data_nxt = {data_r[54:0], 1'b0};
                            crc_nxt  = crc_shift;
                            if (seg_r && cnt_r[2:0] == 3'h7)
                            begin
                                byte_ok_nxt = 1'b0;
                            end
                        end
                        else if (in_crc)
                        begin
                            crc_nxt = {crc_r[14:0], 1'b0};
                        end
                    end
                    else
                    begin
                        sub_nxt = 1'b0;
                        cnt_nxt = cnt_r + 7'd1;
                        if (last_bit)
                        begin
                            cnt_nxt = 7'h00;
                            pos_nxt = 9'h000;
                            sr_nxt  = 8'h00;
                            crc_nxt = `FHE_CRC_INIT;
                            if (!seg_r && clen_r != 4'h0)
                            begin
                                seg_nxt = 1'b1;
                            end
                            else
                            begin
                                state_nxt = FHE_EMIT;
                            end
                        end
                    end
                end
            end
            FHE_EMIT:
            begin
                if (hop_push)
                begin
                    hop_cnt_nxt = hop_cnt_r + 9'd1;
                    p1_nxt      = mulmod(p1_r, `FHE_ALPHA);
                    p2_nxt      = mulmod(p2_r, `FHE_ALPHA_SQ);
                    tmr_nxt     = TMR_LOAD;
                    if (hop_in.last)
                    begin
                        state_nxt = FHE_IDLE;
                    end
                end
            end
            default:
            begin
                state_nxt = FHE_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r   <= FHE_IDLE;
            seg_r     <= 1'b0;
            cnt_r     <= 7'h00;
            sub_r     <= 1'b0;
            pos_r     <= 9'h000;
            sr_r      <= 8'h00;
            data_r    <= 56'h0;
            crc_r     <= 16'h0000;
            byte_ok_r <= 1'b0;
            g2_r      <= 1'b0;
            clen_r    <= 4'h0;
            ref_r     <= 1'b0;
            hop_cnt_r <= 9'h000;
            tmr_r     <= '0;
            p1_r      <= 6'h01;
            p2_r      <= 6'h01;
        end
        else
        begin
            state_r   <= state_nxt;
            seg_r     <= seg_nxt;
            cnt_r     <= cnt_nxt;
            sub_r     <= sub_nxt;
            pos_r     <= pos_nxt;
            sr_r      <= sr_nxt;
            data_r    <= data_nxt;
            crc_r     <= crc_nxt;
            byte_ok_r <= byte_ok_nxt;
            g2_r      <= g2_nxt;
            clen_r    <= clen_nxt;
            ref_r     <= ref_nxt;
            hop_cnt_r <= hop_cnt_nxt;
            tmr_r     <= tmr_nxt;
            p1_r      <= p1_nxt;
            p2_r      <= p2_nxt;
        end
    end

    fhe_sym_mem u_mem
    (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .wr_en   (wr_en),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .rd_addr (rd_addr),
        .rd_data (rd_data)
    );

    // Two-entry output buffer so a modulator stall loses no hop.
    fhe_hop_s   buf0_r, buf0_nxt, buf1_r, buf1_nxt;
    logic [1:0] bcnt_r, bcnt_nxt;
    logic       pop;

    always_comb
    begin
        hop_valid    = bcnt_r != 2'd0;
        hop          = buf0_r;
        buf_in_ready = bcnt_r != 2'd2;
        pop          = hop_valid && hop_ready;
        buf0_nxt     = buf0_r;
        buf1_nxt     = buf1_r;
        bcnt_nxt     = bcnt_r;
        case ({hop_push, pop})
            2'b10:
            begin
                if (bcnt_r == 2'd0)
                begin
                    buf0_nxt = hop_in;
                end
                else
                begin
                    buf1_nxt = hop_in;
                end
                bcnt_nxt = bcnt_r + 2'd1;
            end
            2'b01:
            begin
                buf0_nxt = buf1_r;
                bcnt_nxt = bcnt_r - 2'd1;
            end
            2'b11:
            begin
                if (bcnt_r == 2'd1)
                begin
                    buf0_nxt = hop_in;
                end
                else
                begin
                    buf0_nxt = buf1_r;
                    buf1_nxt = hop_in;
                end
            end
            default:
            begin
                bcnt_nxt = bcnt_r;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            buf0_r <= '0;
            buf1_r <= '0;
            bcnt_r <= 2'd0;
        end
        else
        begin
            buf0_r <= buf0_nxt;
            buf1_r <= buf1_nxt;
            bcnt_r <= bcnt_nxt;
        end
    end

    // Helper state read only by the checks below.
    logic [TW-1:0] gap_r;
    logic          gap_seen_r;
    logic [5:0]    first_blk_r;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gap_r       <= '0;
            gap_seen_r  <= 1'b0;
            first_blk_r <= 6'h00;
        end
        else
        begin
            gap_r      <= hop_push ? '0 : ((gap_r != '1) ? gap_r + TW'(1)
                                                         : gap_r);
            gap_seen_r <= gap_seen_r | hop_push;
            if (hop_push && hop_cnt_r == 9'h000)
            begin
                first_blk_r <= blk;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence first_half_s;
        wr_en && !sub_r;
    endsequence
    sequence second_half_s;
        wr_en && sub_r && (wr_addr != $past(wr_addr));
    endsequence

    check_ref_a: assert property (
        (state_r == FHE_ENC && !seg_r && cnt_r == 7'd56 && !sub_r && ref_r)
        |-> crc_r[15:8] == `FHE_REF_CRC)
        else $error("Reference check value mismatch.");
    sym_pair_a: assert property (
        first_half_s |=> second_half_s)
        else $error("Coded symbol pair not emitted back to back.");
    ilv_step_a: assert property (
        (wr_en && $past(wr_en) && !(sub_r == 1'b0 && cnt_r == 7'd0))
        |-> (wr_addr - base_off) == (($past(pos_r) + 9'd13) % seg_len))
        else $error("Interleaver position step wrong.");
    flush_len_a: assert property (
        (state_r == FHE_ENC && !seg_r && last_bit)
        |-> (cnt_r == 7'd71 && wr_addr == 9'd131))
        else $error("Baseline segment length is not 144 symbols.");
    hop_range_a: assert property (
        hop_push |-> (blk >= 6'd1 && blk <= 6'd46))
        else $error("Hop index out of range.");
    tone_bin_a: assert property (
        hop_valid |-> hop.tone_bin == 7'({hop.block_idx, 1'b0})
                                      + 7'(hop.slot) + 7'd1)
        else $error("Tone bin does not match block and slot.");
    pre_sym_a: assert property (
        (hop_push && hop_cnt_r == 9'd3) |-> hop_in.slot == 1'b0)
        else $error("Preamble symbol wrong.");
    hop_start_a: assert property (
        (ROW0 == 6'd0 && ROW1 == 6'd1 && ROW2 == 6'd0 && hop_push
         && hop_cnt_r == 9'd2) |-> blk == 6'd31)
        else $error("Hop sequence start differs from reference.");
    hop_cycle_a: assert property (
        (hop_push && hop_cnt_r == 9'd46) |-> blk == first_blk_r)
        else $error("Hop sequence does not repeat after 46 hops.");
    chip_pace_a: assert property (
        (hop_push && gap_seen_r && hop_cnt_r != 9'd0)
        |-> gap_r >= TW'(CHIP_CYCLES - 1))
        else $error("Hops released faster than one per chip period.");
    pkt_len_a: assert property (
        (hop_push && hop_in.last && clen_r == 4'h0)
        |-> hop_cnt_r == 9'd175)
        else $error("Baseline packet is not 176 hops.");
endmodule

// ==== hdl/fhe_regs.svh ====
// Constants of the frequency-hopped packet encoder.
`ifndef FHE_REGS_SVH
`define FHE_REGS_SVH
`define FHE_MSG_BITS       7'd56
`define FHE_CRC8_W         7'd8
`define FHE_CRC16_W        7'd16
`define FHE_FLUSH_BITS     7'd8
`define FHE_BASE_SYMS      9'd144
`define FHE_ILV_STEP       9'd13
`define FHE_PRIME          6'd47
`define FHE_ALPHA          6'd5
`define FHE_ALPHA_SQ       6'd25
`define FHE_PRE_HOPS       9'd32
`define FHE_PRE_PATTERN    32'h6bc4d788
`define FHE_G1_TAPS        9'h1af
`define FHE_G2_TAPS        9'h11d
`define FHE_CRC8_POLY      8'h07
`define FHE_CRC16_POLY     16'h1021
`define FHE_CRC_INIT       16'h0000
`define FHE_REF_MSG        56'h323110557733ee
`define FHE_REF_CRC        8'hf4
`define FHE_MAX_CARGO      4'd8
`define FHE_CLK_PERIOD_NS  5
`define FHE_CHIP_PERIOD_NS 12500000
`define FHE_MEM_AW         9
`define FHE_MEM_DEPTH      512
`endif

// ==== hdl/fhe_pkg.sv ====
// Types shared by the packet encoder files.
package fhe_pkg;
    typedef enum logic [1:0] {FHE_IDLE, FHE_ENC, FHE_EMIT} fhe_state_e;
    typedef struct packed {
        logic [55:0] msg;
        logic [3:0]  cargo_len;
    } fhe_msg_s;
    typedef struct packed {
        logic [5:0] block_idx;
        logic       slot;
        logic [6:0] tone_bin;
        logic       last;
    } fhe_hop_s;
endpackage

// ==== hdl/fhe_sym_mem.sv ====
// Coded symbol store with one write port and a registered read port.
`timescale 1ns/1ps
`include "fhe_regs.svh"
module fhe_sym_mem
(
    // Clock and reset.
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    // Write port.
    input  wire logic                   wr_en,
    input  wire logic [`FHE_MEM_AW-1:0] wr_addr,
    input  wire logic                   wr_data,
    // Read port.
    input  wire logic [`FHE_MEM_AW-1:0] rd_addr,
    output logic                        rd_data
);
    logic mem_r [`FHE_MEM_DEPTH];

    // The array itself holds no reset.
    always_ff @(posedge sys_clk)
    begin
        if (wr_en)
        begin
            mem_r[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data <= 1'b0;
        end
        else
        begin
            rd_data <= mem_r[rd_addr];
        end
    end
endmodule

// ==== tb/fhe_mod_model.sv ====
// Chip modulator model that takes hops promptly or with long stalls.
`timescale 1ns/1ps
module fhe_mod_model
(
    // Clock and reset.
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // Hop handshake.
    input  wire logic hop_valid,
    input  wire logic slow,
    output logic      hop_ready
);
    logic [7:0] stall_r;
    initial stall_r = 8'h5b;
    initial hop_ready = 1'b0;
    // Stalls leave the encoder's two-entry buffer full for many cycles.
    always @(posedge sys_clk)
    begin
        if (hop_valid)
            stall_r <= #1 {stall_r[6:0],
                           stall_r[7] ^ stall_r[5] ^ stall_r[4] ^ stall_r[3]};
        hop_ready <= #1 rst_n && (!slow || stall_r[2:0] == 3'h0);
    end
endmodule

// ==== tb/tb_fhe_packet_encoder.sv ====
// Self-checking bench of the packet encoder against a modulator model.
`timescale 1ns/1ps
module tb_fhe_packet_encoder;
    import fhe_pkg::*;
    localparam int          CHIP = 8;
    localparam logic [31:0] PRE  = 32'h6bc4d788;
    logic        sys_clk, rst_n, msg_valid, msg_ready, cargo_valid;
    logic        cargo_ready, hop_valid, hop_ready, slow;
    logic [7:0]  cargo_byte;
    logic [5:0]  hidx;
    logic [31:0] rnd;
    fhe_msg_s    msg;
    fhe_hop_s    hop, exp_q[$];
    int          error_cnt, n_compared, cyc, last_take, pos;

    fhe_packet_encoder #(.CHIP_CYCLES(CHIP)) dut (.sys_clk(sys_clk),
        .rst_n(rst_n), .msg_valid(msg_valid), .msg_ready(msg_ready),
        .msg(msg), .cargo_valid(cargo_valid), .cargo_ready(cargo_ready),
        .cargo_byte(cargo_byte), .hop_valid(hop_valid),
        .hop_ready(hop_ready), .hop(hop));
    fhe_mod_model model (.sys_clk(sys_clk), .rst_n(rst_n),
        .hop_valid(hop_valid), .slow(slow), .hop_ready(hop_ready));

    function automatic logic [15:0] crc(input logic b[$], input int w,
                                        input logic [15:0] p);
        logic [15:0] r;
        r = '0;
        foreach (b[i])
            r = ((r << 1) ^ ((r[w-1] ^ b[i]) ? p : 16'h0)) & 16'((1 << w) - 1);
        return r;
    endfunction

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic add_hop(input logic s);
        hidx = 6'((int'(hidx) * 5) % 47);
        exp_q.push_back('{hidx, s, 7'(2 * hidx + s + 1), 1'b0});
    endtask

    task automatic push_syms(input logic b[$]);
        logic [8:0] sr;
        logic       c[$];
        logic       o[$];
        sr = '0;
        for (int i = 0; i < 8; i++)
            b.push_back(1'b0);
        foreach (b[i])
        begin
            sr = {sr[7:0], b[i]};
            c.push_back(^(sr & 9'h1af));
            c.push_back(^(sr & 9'h11d));
        end
        o = c;
        foreach (c[j])
            o[(13 * j) % c.size()] = c[j];
        foreach (o[j])
            add_hop(o[j]);
    endtask

    task automatic build(input logic [55:0] m, input int nb,
                         input logic [63:0] cb);
        logic        b[$];
        logic [15:0] k;
        hidx = 6'd1;
        for (int i = 31; i >= 0; i--)
            add_hop(PRE[i]);
        for (int i = 55; i >= 0; i--)
            b.push_back(m[i]);
        k = crc(b, 8, 16'h0007);
        for (int i = 7; i >= 0; i--)
            b.push_back(k[i]);
        push_syms(b);
        b = {};
        for (int i = 8 * nb - 1; i >= 0; i--)
            b.push_back(cb[i]);
        k = crc(b, 16, 16'h1021);
        for (int i = 15; i >= 0 && nb > 0; i--)
            b.push_back(k[i]);
        if (nb > 0)
            push_syms(b);
        exp_q[exp_q.size() - 1].last = 1'b1;
    endtask

    task automatic send(input logic [55:0] m, input int nb,
                        input logic [63:0] cb);
        build(m, nb, cb);
        msg = '{m, 4'(nb)};
        msg_valid = 1'b1;
        while (msg_ready !== 1'b1)
            @(posedge sys_clk) #1;
        @(posedge sys_clk) #1;
        msg_valid = 1'b0;
        for (int i = nb - 1; i >= 0; i--)
        begin
            cargo_byte = cb[8 * i +: 8];
            cargo_valid = 1'b1;
            while (cargo_ready !== 1'b1)
                @(posedge sys_clk) #1;
            @(posedge sys_clk) #1;
        end
        cargo_valid = 1'b0;
    endtask

    task automatic drain();
        while (exp_q.size() != 0)
            @(posedge sys_clk) #1;
    endtask

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Every taken hop is compared in order; fast mode also checks pacing.
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc > 20000)
        begin
            error_cnt++;
            final_report();
        end
        else if (rst_n && hop_valid && hop_ready)
        begin
            n_compared++;
            if (exp_q.size() == 0 || hop !== exp_q[0])
            begin
                error_cnt++;
                $display("wrong value hop exp %h seen %h", exp_q[0], hop);
            end
            if (!slow && pos > 0 && cyc - last_take != CHIP)
            begin
                error_cnt++;
                $display("wrong value hop gap exp %0d seen %0d", CHIP,
                         cyc - last_take);
            end
            pos = (exp_q.size() != 0 && exp_q[0].last) ? 0 : pos + 1;
            if (exp_q.size() != 0)
                void'(exp_q.pop_front());
            last_take = cyc;
        end
    end

    initial
    begin
        sys_clk = 1'b0;
        forever
            #2.5 sys_clk = ~sys_clk;
    end

    initial
    begin
        {rst_n, msg_valid, cargo_valid, slow} = 4'h0;
        {cargo_byte, msg, rnd} = '0;
        {error_cnt, n_compared, cyc, last_take, pos} = '0;
        rnd = 32'hb41b;
        repeat (16)
            @(posedge sys_clk);
        #1 rst_n = 1'b1;
        send(56'h323110557733ee, 0, 64'h0);
        drain();
        for (int p = 0; p < 3; p++)
        begin
            slow = (p == 0);
            rnd = lfsr(rnd);
            send({rnd, rnd[23:0] ^ 24'h5a5a5a}, 2 + 6 * (p % 2),
                 {rnd, ~rnd});
            if (p != 1)
                drain();
        end
        final_report();
    end
endmodule
